// File: src/jdp_pkg.sv
// jdp_pkg: constants, pin carrier and tap state encoding for the test/debug port
// assumes one 40 MHz core clock samples every test pin
package jdp_pkg;

    localparam int CLK_PERIOD_NS = 25;
    localparam int DE_PULSE_NS = 100;
    localparam int DE_PULSE_CYC = (DE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DE_CNT_W = 3;

    localparam int IR_W = 4;
    localparam int DR_W = 32;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_W-1:0] INSTR_IDCODE = 4'h2;
    localparam logic [IR_W-1:0] INSTR_BYPASS = 4'hf;
    // identity value is arbitrary and names no maker
    localparam logic [DR_W-1:0] ID_VALUE = 32'h0000_0001;
    localparam int TMS_RESET_RISES = 5;

    // undriven pin levels: clock low, the rest high
    localparam logic PULL_TCK = 1'h0;
    localparam logic PULL_TMS = 1'h1;
    localparam logic PULL_TDI = 1'h1;
    localparam logic PULL_TRST = 1'h1;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } jdp_pins_t;

    localparam jdp_pins_t PINS_PULLED = '{tck: PULL_TCK, tms: PULL_TMS, tdi: PULL_TDI, trst_n: PULL_TRST};

    typedef enum logic [15:0] {
        TLR = 16'h0001,
        RTI = 16'h0002,
        SEL_DR = 16'h0004,
        CAP_DR = 16'h0008,
        SHIFT_DR = 16'h0010,
        EXIT1_DR = 16'h0020,
        PAUSE_DR = 16'h0040,
        EXIT2_DR = 16'h0080,
        UPD_DR = 16'h0100,
        SEL_IR = 16'h0200,
        CAP_IR = 16'h0400,
        SHIFT_IR = 16'h0800,
        EXIT1_IR = 16'h1000,
        PAUSE_IR = 16'h2000,
        EXIT2_IR = 16'h4000,
        UPD_IR = 16'h8000
    } jdp_tap_t;

endpackage

// File: src/jdp_port.sv
// jdp_port: test access port, serial test data path and debug-event strobe
// assumes pins arrive asynchronously; tck much slower than clk (>= 4 clk per half period)
`timescale 1ns/1ps
`default_nettype none
module jdp_port
    import jdp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire jdp_pins_t pins,
    input wire logic debug_event,
    output logic tdo_out,
    output logic tdo_oe,
    output logic debug_event_out_n
);

    function automatic jdp_tap_t tap_step(input jdp_tap_t s, input logic tms);
        unique case (s)
            TLR: tap_step = tms ? TLR : RTI;
            RTI: tap_step = tms ? SEL_DR : RTI;
            SEL_DR: tap_step = tms ? SEL_IR : CAP_DR;
            CAP_DR: tap_step = tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: tap_step = tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: tap_step = tms ? UPD_DR : PAUSE_DR;
            PAUSE_DR: tap_step = tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: tap_step = tms ? UPD_DR : SHIFT_DR;
            UPD_DR: tap_step = tms ? SEL_DR : RTI;
            SEL_IR: tap_step = tms ? TLR : CAP_IR;
            CAP_IR: tap_step = tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: tap_step = tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: tap_step = tms ? UPD_IR : PAUSE_IR;
            PAUSE_IR: tap_step = tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: tap_step = tms ? UPD_IR : SHIFT_IR;
            UPD_IR: tap_step = tms ? SEL_IR : RTI;
            default: tap_step = TLR;
        endcase
    endfunction

    // pin synchronisers; reset to the pulled levels so an open port idles safely
    jdp_pins_t pins_s1;
    jdp_pins_t pins_s2;
    logic tck_d;

    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            pins_s1 <= PINS_PULLED;
            pins_s2 <= PINS_PULLED;
            tck_d <= PULL_TCK;
        end else begin
            pins_s1 <= pins;
            pins_s2 <= pins_s1;
            tck_d <= pins_s2.tck;
        end
    end

    logic tck_rise;
    logic tck_fall;
    logic trst_low;
    assign tck_rise = pins_s2.tck & ~tck_d;
    assign tck_fall = ~pins_s2.tck & tck_d;
    assign trst_low = ~pins_s2.trst_n;

    // tap group; reset only by power-on or test reset, never by rst_n
    jdp_tap_t state;
    jdp_tap_t next_state;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] next_ir;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] next_ir_sh;
    logic [DR_W-1:0] dr;
    logic [DR_W-1:0] next_dr;
    logic next_tdo_out;
    logic next_tdo_oe;
    logic in_shift;
    logic bypass_sel;

    assign in_shift = (state == SHIFT_IR) || (state == SHIFT_DR);
    assign bypass_sel = (ir != INSTR_IDCODE);

    always_comb begin
        next_state = state;
        next_ir = ir;
        next_ir_sh = ir_sh;
        next_dr = dr;
        next_tdo_out = tdo_out;
        next_tdo_oe = tdo_oe;
        if (trst_low) begin
            next_state = TLR;
            next_ir = INSTR_IDCODE;
            next_tdo_oe = 1'h0;
        end else begin
            if (tck_rise) begin
                next_state = tap_step(state, pins_s2.tms);
                unique case (state)
                    TLR: next_ir = INSTR_IDCODE;
                    CAP_IR: next_ir_sh = IR_CAPTURE;
                    SHIFT_IR: next_ir_sh = {pins_s2.tdi, ir_sh[IR_W-1:1]};
                    UPD_IR: next_ir = ir_sh;
                    CAP_DR: next_dr = bypass_sel ? '0 : ID_VALUE;
                    SHIFT_DR: begin
                        if (bypass_sel) begin
                            next_dr = {{(DR_W-1){1'h0}}, pins_s2.tdi};
                        end else begin
                            next_dr = {pins_s2.tdi, dr[DR_W-1:1]};
                        end
                    end
                    default: ;
                endcase
            end
            if (tck_fall) begin
                // drive only from the shift states; data moves half a cycle before sampling
                next_tdo_oe = in_shift;
                next_tdo_out = (state == SHIFT_IR) ? ir_sh[0] : dr[0];
            end
        end
    end

    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            state <= TLR;
            ir <= INSTR_IDCODE;
            ir_sh <= IR_CAPTURE;
            dr <= '0;
            tdo_out <= 1'h0;
            tdo_oe <= 1'h0;
        end else begin
            state <= next_state;
            ir <= next_ir;
            ir_sh <= next_ir_sh;
            dr <= next_dr;
            tdo_out <= next_tdo_out;
            tdo_oe <= next_tdo_oe;
        end
    end

    // debug-event strobe; belongs to the core side, so device reset applies
    logic [DE_CNT_W-1:0] de_cnt;
    logic [DE_CNT_W-1:0] next_de_cnt;
    logic next_debug_event_out_n;

    always_comb begin
        next_de_cnt = de_cnt;
        next_debug_event_out_n = debug_event_out_n;
        if (de_cnt != '0) begin
            next_de_cnt = de_cnt - 1'h1;
            next_debug_event_out_n = (de_cnt == 3'h1);
        end else if (debug_event) begin
            // events during a running pulse merge into it; a pulse is never stretched
            next_de_cnt = DE_CNT_W'(DE_PULSE_CYC);
            next_debug_event_out_n = 1'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            de_cnt <= '0;
            debug_event_out_n <= 1'h1;
        end else begin
            de_cnt <= next_de_cnt;
            debug_event_out_n <= next_debug_event_out_n;
        end
    end

    // helper: consecutive rising edges with tms high
    logic [2:0] tms_hi_cnt;
    logic [2:0] next_tms_hi_cnt;

    always_comb begin
        next_tms_hi_cnt = tms_hi_cnt;
        if (tck_rise) begin
            next_tms_hi_cnt = !pins_s2.tms ? 3'h0 : (tms_hi_cnt == 3'h7 ? 3'h7 : tms_hi_cnt + 3'h1);
        end
    end

    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            tms_hi_cnt <= 3'h0;
        end else begin
            tms_hi_cnt <= next_tms_hi_cnt;
        end
    end

    chk_tdo_release_idle: assert property (@(posedge clk) disable iff (!por_n)
        (tck_fall && !in_shift) || trst_low |=> !tdo_oe)
        else $error("tdo driven outside a shift state");

    chk_tdo_on_fall: assert property (@(posedge clk) disable iff (!por_n)
        $changed(tdo_out) |-> $past(tck_fall))
        else $error("tdo changed away from a falling test clock edge");

    chk_trst_resets_tap: assert property (@(posedge clk) disable iff (!por_n)
        trst_low |=> state == TLR && ir == INSTR_IDCODE)
        else $error("test reset did not reset the tap");

    chk_five_tms_high: assert property (@(posedge clk) disable iff (!por_n)
        tms_hi_cnt >= 3'(TMS_RESET_RISES) |-> state == TLR)
        else $error("five tms-high rises did not reach test-logic-reset");

    chk_state_on_rise: assert property (@(posedge clk) disable iff (!por_n)
        $changed(state) |-> $past(tck_rise) || $past(trst_low))
        else $error("tap state moved without a rising test clock edge");

    chk_tdi_capture: assert property (@(posedge clk) disable iff (!por_n)
        tck_rise && !trst_low && state == SHIFT_DR && bypass_sel |=> dr[0] == $past(pins_s2.tdi))
        else $error("tdi not captured on rising edge");

    chk_dev_reset_keeps: assert property (@(posedge clk) disable iff (!por_n)
        !rst_n && !trst_low && !tck_rise |=> $stable(state) && $stable(ir))
        else $error("device reset disturbed the test module");

    chk_debug_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        debug_event && de_cnt == 3'h0 |=> !debug_event_out_n [*4] ##1 debug_event_out_n)
        else $error("debug event pulse has wrong length");

    chk_ir_shift_oe: assert property (@(posedge clk) disable iff (!por_n)
        tck_fall && !trst_low && state == SHIFT_IR |=> tdo_oe && tdo_out == $past(ir_sh[0]))
        else $error("tdo not driven with ir data in shift-ir");

endmodule
`default_nettype wire

// File: verif/jdp_host.sv
// jdp_host: test host model, drives the port pins with a 200 ns test clock
// assumes the bench calls clock_bit just after a falling core clock edge
`timescale 1ns/1ps
`default_nettype none
module jdp_host
    import jdp_pkg::*;
(
    input wire logic clk,
    input wire logic tdo_out,
    input wire logic tdo_oe,
    output var jdp_pins_t pins,
    output var logic [1:0] seen
);
    logic tdo_last;
    logic tdo_pin;
    event done;
    // no pull on tdo: a released pin shows the inverse of its last level
    assign tdo_pin = tdo_oe ? tdo_out : ~tdo_last;
    always @(posedge clk) if (tdo_oe) tdo_last <= tdo_out;
    initial begin
        tdo_last = 1'h0;
        seen = 2'h0;
        pins = PINS_PULLED;
    end
    // tms and tdi move one core cycle ahead of the rise, so they never change with it
    task automatic clock_bit(input logic tms, input logic tdi);
        pins.tms = tms;
        pins.tdi = tdi;
        @(negedge clk);
        pins.tck = 1'h1;
        repeat (4) @(negedge clk);
        pins.tck = 1'h0;
        repeat (3) @(negedge clk);
        seen = {tdo_oe, tdo_oe & tdo_pin};
        ->done;
    endtask
    task automatic test_reset(input int cycles);
        pins.trst_n = 1'h0;
        repeat (cycles) @(negedge clk);
        pins.trst_n = 1'h1;
    endtask
endmodule
`default_nettype wire

// File: verif/jdp_port_tb.sv
// jdp_port_tb: self-checking bench for the test access port and debug strobe
// assumes jdp_host as the far side; expectations queued, monitors compare
`timescale 1ns/1ps
`default_nettype none
module jdp_port_tb;
    import jdp_pkg::*;
    logic clk, rst_n, por_n, debug_event, tdo_out, tdo_oe, debug_event_out_n;
    jdp_pins_t pins;
    logic [1:0] pin_q[$];
    int dbg_q[$];
    logic tdr[$];
    logic [IR_W-1:0] irs[3];
    int miscompares = 0, checks = 0, low_len = 0;
    jdp_port jdp_port_inst(.clk(clk), .rst_n(rst_n), .por_n(por_n), .pins(pins), .debug_event(debug_event),
        .tdo_out(tdo_out), .tdo_oe(tdo_oe), .debug_event_out_n(debug_event_out_n));
    jdp_host jdp_host_inst(.clk(clk), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .pins(pins), .seen());
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic step(input logic tms, input logic tdi, input logic eoe, input logic eout);
        pin_q.push_back({eoe, eoe & eout});
        jdp_host_inst.clock_bit(tms, tdi);
    endtask
    // shift n bits through a len-bit register loaded with cap, then back to idle
    task automatic shift(input logic [31:0] cap, input int len, input int n, input logic [63:0] din);
        tdr.delete();
        for (int i = 0; i < len; i++) tdr.push_back(cap[i]);
        step(1'h0, 1'h1, 1'h1, tdr[0]);
        for (int i = 0; i < n; i++) begin
            tdr.push_back(din[i]);
            void'(tdr.pop_front());
            // device reset alone must not disturb a shift in progress
            if (i == 5) begin
                rst_n = 1'h0;
                @(negedge clk);
                rst_n = 1'h1;
            end
            step(i == n - 1, din[i], i != n - 1, tdr[0]);
        end
        step(1'h1, 1'h1, 1'h0, 1'h0);
        step(1'h0, 1'h1, 1'h0, 1'h0);
    endtask
    task automatic scan_dr(input logic [IR_W-1:0] ir);
        logic id;
        id = (ir == INSTR_IDCODE);
        step(1'h1, 1'h1, 1'h0, 1'h0);
        step(1'h0, 1'h1, 1'h0, 1'h0);
        shift(id ? ID_VALUE : 32'h0, id ? DR_W : 1, id ? DR_W + 2 : 3, {$urandom, $urandom});
    endtask
    task automatic scan_ir(input logic [IR_W-1:0] ir);
        step(1'h1, 1'h1, 1'h0, 1'h0);
        step(1'h1, 1'h1, 1'h0, 1'h0);
        step(1'h0, 1'h1, 1'h0, 1'h0);
        shift({28'h0, IR_CAPTURE}, IR_W, IR_W, {60'h0, ir});
    endtask
    // read the host's own variable: a port copy may not have settled when the event fires
    always @(jdp_host_inst.done) begin
        check(jdp_host_inst.seen, pin_q.pop_front());
    end
    always @(negedge clk) begin
        if (debug_event_out_n === 1'h0) low_len <= low_len + 1;
        else if (low_len != 0) begin
            check(low_len, dbg_q.pop_front());
            low_len <= 0;
        end
    end
    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end
    initial begin
        rst_n = 1'h0;
        por_n = 1'h0;
        debug_event = 1'h0;
        void'($urandom(45685));
        irs = '{4'h0, INSTR_IDCODE, INSTR_BYPASS};
        irs[0] = IR_W'($urandom);
        @(negedge clk);
        jdp_host_inst.test_reset(3);
        por_n = 1'h1;
        rst_n = 1'h1;
        repeat (3) @(negedge clk);
        for (int i = 0; i < TMS_RESET_RISES; i++) step(1'h1, 1'h0, 1'h0, 1'h0);
        step(1'h0, 1'h1, 1'h0, 1'h0);
        scan_dr(INSTR_IDCODE);
        foreach (irs[k]) begin
            scan_ir(irs[k]);
            scan_dr(irs[k]);
        end
        // test reset in mid data shift: tap must leave shift-dr and restore the identity instruction
        step(1'h1, 1'h1, 1'h0, 1'h0);
        step(1'h0, 1'h1, 1'h0, 1'h0);
        step(1'h0, 1'h1, 1'h1, 1'h0);
        jdp_host_inst.test_reset(3);
        step(1'h0, 1'h1, 1'h0, 1'h0);
        scan_dr(INSTR_IDCODE);
        // five tms-high rises out of shift-dr must reach test-logic-reset; the next rise, out of it, restores the identity instruction
        scan_ir(INSTR_BYPASS);
        step(1'h1, 1'h1, 1'h0, 1'h0);
        step(1'h0, 1'h1, 1'h0, 1'h0);
        step(1'h0, 1'h1, 1'h1, 1'h0);
        for (int i = 0; i < TMS_RESET_RISES; i++) step(1'h1, 1'h0, 1'h0, 1'h0);
        step(1'h0, 1'h1, 1'h0, 1'h0);
        scan_dr(INSTR_IDCODE);
        // the last event lasts two cycles and must merge into one strobe
        for (int i = 0; i < 6; i++) begin
            debug_event = 1'h1;
            dbg_q.push_back(DE_PULSE_CYC);
            repeat (i == 5 ? 2 : 1) @(negedge clk);
            debug_event = 1'h0;
            repeat (DE_PULSE_CYC + $urandom_range(3)) @(negedge clk);
        end
        repeat (10) @(negedge clk);
        check(pin_q.size(), 0);
        check(dbg_q.size(), 0);
        wrap_up();
    end
endmodule
`default_nettype wire
